// File: rafrs_checker.sv
// port-level assertions for the address filter and ring setup block
`timescale 1ns/1ps
module rafrs_checker (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] o_prdata,
    input wire [15:0] i_rx_buf_len,
    input wire o_rx_accept,
    input wire o_rx_reject,
    input wire o_rx_group,
    input wire o_tx_ring_enable,
    input wire o_rx_ring_enable,
    input wire o_tx_chain_allow,
    input wire o_rx_chain_allow,
    input wire [23:0] o_rx_ring_base,
    input wire [7:0] o_rx_ring_entries
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    wire ctrl_wr = i_psel && i_penable && i_pwrite && i_paddr == 8'h00;
    chain_limit_a: assert property (
        o_rx_chain_allow == (o_tx_chain_allow || i_rx_buf_len == 16'h0020))
        else $error("rx chaining allowance wrong");
    ring_base_a: assert property (o_rx_ring_base[2:0] == 3'h0)
        else $error("ring base not quadword aligned");
    ring_len_a: assert property ($onehot(o_rx_ring_entries))
        else $error("ring entry count not a power of two");
    ring_resv_a: assert property (
        i_psel && !i_penable && !i_pwrite && i_paddr == 8'h24
        |=> o_prdata[28:24] == 5'h0 && o_prdata[2:0] == 3'h0)
        else $error("ring pointer zero bits read nonzero");
    one_verdict_a: assert property (!(o_rx_accept && o_rx_reject))
        else $error("accept and reject together");
    verdict_pulse_a: assert property (
        o_rx_accept || o_rx_reject |=> !o_rx_accept && !o_rx_reject)
        else $error("verdict longer than one cycle");
    rx_off_a: assert property (o_rx_accept |-> $past(o_rx_ring_enable))
        else $error("frame accepted with receiver off");
    group_flag_a: assert property ($changed(o_rx_group) |-> o_rx_accept || o_rx_reject)
        else $error("group flag moved without a verdict");
    tx_start_a: assert property ($rose(o_tx_ring_enable) |-> $past(ctrl_wr))
        else $error("tx ring enabled without control write");
    rx_start_a: assert property ($rose(o_rx_ring_enable) |-> $past(ctrl_wr))
        else $error("rx ring enabled without control write");
endmodule

// File: rafrs_consts.vh
// register offsets, field positions and constants of the address filter and ring setup block
`ifndef RAFRS_CONSTS_VH
`define RAFRS_CONSTS_VH

`define RAFRS_ADDR_W 8
`define RAFRS_OFF_CTRL 8'h00
`define RAFRS_OFF_MODE 8'h04
`define RAFRS_OFF_STA0 8'h08
`define RAFRS_OFF_STA1 8'h0c
`define RAFRS_OFF_STA2 8'h10
`define RAFRS_OFF_HASH0 8'h14
`define RAFRS_OFF_HASH1 8'h18
`define RAFRS_OFF_HASH2 8'h1c
`define RAFRS_OFF_HASH3 8'h20
`define RAFRS_OFF_RING 8'h24

`define RAFRS_CTRL_INIT 0
`define RAFRS_CTRL_START 1
`define RAFRS_CTRL_STOP 2
`define RAFRS_CTRL_TX_ON 4
`define RAFRS_CTRL_RX_ON 5
`define RAFRS_CTRL_INIT_DONE 8

`define RAFRS_MODE_RX_DISABLE 0
`define RAFRS_MODE_TX_DISABLE 1
`define RAFRS_MODE_LOOP 2
`define RAFRS_MODE_TX_CRC_DISABLE 3
`define RAFRS_MODE_INTL 6
`define RAFRS_MODE_RESET 16'h0000

`define RAFRS_RING_LEN_HI 31
`define RAFRS_RING_LEN_LO 29
`define RAFRS_RING_BASE_HI 23
`define RAFRS_RING_BASE_LO 3
`define RAFRS_RING_MASK 32'he0fffff8

`define RAFRS_LOOP_CHAIN_BYTES 16'h0020
`define RAFRS_ADDR_BITS 48
`define RAFRS_LAST_BIT 6'h2f
`define RAFRS_CRC_INIT 32'hffffffff
`define RAFRS_CRC_POLY 32'hedb88320

`endif

// File: rafrs_crc_hash.v
// serial ethernet crc over a destination address, latching the hash index
`timescale 1ns/1ps
`include "rafrs_consts.vh"
module rafrs_crc_hash (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_clear,
    input wire i_bit,
    input wire i_bit_valid,
    input wire i_last,
    output reg [5:0] o_index
);
    reg [31:0] crc;
    reg [31:0] next_crc;

    // reflected form: first bit on the wire enters at bit 0
    always @* begin
        next_crc = {1'b0, crc[31:1]};
        if (crc[0] ^ i_bit) begin
            next_crc = next_crc ^ `RAFRS_CRC_POLY;
        end
    end

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            crc <= `RAFRS_CRC_INIT;
            o_index <= 6'h00;
        end else if (i_clear) begin
            crc <= `RAFRS_CRC_INIT;
        end else if (i_bit_valid) begin
            crc <= next_crc;
            if (i_last) begin
                o_index <= next_crc[31:26];
            end
        end
    end
endmodule

// File: rafrs_frame_src.sv
// serial destination address source standing in for the line side
`timescale 1ns/1ps
module rafrs_frame_src (
    input wire i_core_clk,
    input wire i_go,
    input wire [47:0] i_addr,
    output logic o_start = 1'b0,
    output logic o_bit = 1'b0,
    output logic o_valid = 1'b0
);
    logic [5:0] n = 6'h0;
    always @(posedge i_core_clk) begin
        o_start <= n == 6'h0 && i_go;
        if (n == 6'h0 && i_go) begin
            n <= 6'h1;
        end else if (n != 6'h0 && n <= 6'h30) begin
            o_valid <= 1'b1;
            o_bit <= i_addr[n - 6'h1];
            n <= n + 6'h1;
        end else begin
            o_valid <= 1'b0;
            // idle line toggles so no stale bit looks valid
            o_bit <= ~o_bit;
            n <= 6'h0;
        end
    end
endmodule

// File: rafrs_ring_decode.v
// decodes the receive ring pointer into base address and entry count
`timescale 1ns/1ps
`include "rafrs_consts.vh"
module rafrs_ring_decode (
    input wire [31:0] i_ring_ptr,
    output wire [23:0] o_base,
    output wire [7:0] o_entries
);
    assign o_entries = 8'h01 << i_ring_ptr[`RAFRS_RING_LEN_HI:`RAFRS_RING_LEN_LO];
    assign o_base = {i_ring_ptr[`RAFRS_RING_BASE_HI:`RAFRS_RING_BASE_LO], 3'h0};
endmodule

// File: rafrs_top.v
// receive address filter and ring setup registers behind an apb slave
// What this block does
// - loopback: no tx chaining, rx chaining 32-byte buffers
// - tx disable stops tx ring, clears tx on
// - rx disable drops frames, clears rx on
// - station address register matches individual frames
// - first address bit one means group address
// - full 64-bit group hash mask held
// - crc-32 over 48 bits, top six index
// - selected mask bit accepts, zero rejects
// - broadcast accepted whenever rx is on, bypassing the hash
// - external loopback filters groups only with crc disable
// - ring length field decodes as power two
// - ring pointer reserved bits read zero
// - ring base on quadword boundary, low bits zero
// - rings and traffic start only after start bit
`timescale 1ns/1ps
`include "rafrs_consts.vh"
module rafrs_top (
    input wire i_core_clk,
    input wire i_rst,
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output reg [31:0] o_prdata,
    output wire o_pready,
    output reg o_pslverr,
    input wire i_rx_frame_start,
    input wire i_rx_bit,
    input wire i_rx_bit_valid,
    input wire [15:0] i_rx_buf_len,
    output reg o_rx_accept,
    output reg o_rx_reject,
    output reg o_rx_group,
    output wire o_tx_ring_enable,
    output wire o_rx_ring_enable,
    output wire o_tx_chain_allow,
    output wire o_rx_chain_allow,
    output wire [23:0] o_rx_ring_base,
    output wire [7:0] o_rx_ring_entries
);
    reg [15:0] mode;
    reg [47:0] station;
    reg [63:0] hash_mask;
    reg [31:0] ring_ptr;
    reg init_done;
    reg started;
    reg tx_dis_active;
    reg rx_dis_active;
    reg tx_on;
    reg rx_on;

    reg [5:0] bit_cnt;
    reg in_addr;
    reg [47:0] addr;
    reg decide;
    reg [31:0] next_rdata;
    reg next_err;
    reg next_accept;

    wire setup_phase;
    wire wr_en;
    wire last_bit;
    wire [5:0] hash_index;
    wire loop_on;
    wire ext_loop;
    wire group_addr;
    wire broadcast;
    wire [31:0] ctrl_view;

    // zero wait states: read data is captured in the setup cycle
    assign o_pready = 1'b1;
    assign setup_phase = i_psel & ~i_penable;
    assign wr_en = i_psel & i_penable & i_pwrite & o_pready;

    assign loop_on = mode[`RAFRS_MODE_LOOP];
    assign ext_loop = loop_on & ~mode[`RAFRS_MODE_INTL];

    assign ctrl_view = {23'h000000, init_done, 2'h0, rx_on, tx_on, 1'b0,
                        ~started, started, 1'b0};

    // address decode for reads and the error answer
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        if (i_paddr == `RAFRS_OFF_CTRL) begin
            next_rdata = ctrl_view;
        end else if (i_paddr == `RAFRS_OFF_MODE) begin
            next_rdata = {16'h0000, mode};
        end else if (i_paddr == `RAFRS_OFF_STA0) begin
            next_rdata = {16'h0000, station[15:0]};
        end else if (i_paddr == `RAFRS_OFF_STA1) begin
            next_rdata = {16'h0000, station[31:16]};
        end else if (i_paddr == `RAFRS_OFF_STA2) begin
            next_rdata = {16'h0000, station[47:32]};
        end else if (i_paddr == `RAFRS_OFF_HASH0) begin
            next_rdata = {16'h0000, hash_mask[15:0]};
        end else if (i_paddr == `RAFRS_OFF_HASH1) begin
            next_rdata = {16'h0000, hash_mask[31:16]};
        end else if (i_paddr == `RAFRS_OFF_HASH2) begin
            next_rdata = {16'h0000, hash_mask[47:32]};
        end else if (i_paddr == `RAFRS_OFF_HASH3) begin
            next_rdata = {16'h0000, hash_mask[63:48]};
        end else if (i_paddr == `RAFRS_OFF_RING) begin
            next_rdata = ring_ptr & `RAFRS_RING_MASK;
        end else begin
            next_err = 1'b1;
        end
    end

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_prdata <= 32'h00000000;
            o_pslverr <= 1'b0;
        end else if (setup_phase) begin
            o_prdata <= i_pwrite ? 32'h00000000 : next_rdata;
            o_pslverr <= next_err;
        end
    end

    // configuration registers
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            mode <= `RAFRS_MODE_RESET;
            station <= 48'h000000000000;
            hash_mask <= 64'h0000000000000000;
            ring_ptr <= 32'h00000000;
        end else if (wr_en) begin
            if (i_paddr == `RAFRS_OFF_MODE) begin
                mode <= i_pwdata[15:0];
            end else if (i_paddr == `RAFRS_OFF_STA0) begin
                station[15:0] <= i_pwdata[15:0];
            end else if (i_paddr == `RAFRS_OFF_STA1) begin
                station[31:16] <= i_pwdata[15:0];
            end else if (i_paddr == `RAFRS_OFF_STA2) begin
                station[47:32] <= i_pwdata[15:0];
            end else if (i_paddr == `RAFRS_OFF_HASH0) begin
                hash_mask[15:0] <= i_pwdata[15:0];
            end else if (i_paddr == `RAFRS_OFF_HASH1) begin
                hash_mask[31:16] <= i_pwdata[15:0];
            end else if (i_paddr == `RAFRS_OFF_HASH2) begin
                hash_mask[47:32] <= i_pwdata[15:0];
            end else if (i_paddr == `RAFRS_OFF_HASH3) begin
                hash_mask[63:48] <= i_pwdata[15:0];
            end else if (i_paddr == `RAFRS_OFF_RING) begin
                // reserved and sub-quadword bits are never stored
                ring_ptr <= i_pwdata & `RAFRS_RING_MASK;
            end
        end
    end

    // control: init snapshots the disable bits, start turns traffic on
    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            init_done <= 1'b0;
            started <= 1'b0;
            tx_dis_active <= 1'b1;
            rx_dis_active <= 1'b1;
            tx_on <= 1'b0;
            rx_on <= 1'b0;
        end else if (wr_en && i_paddr == `RAFRS_OFF_CTRL && i_pwdata[`RAFRS_CTRL_STOP]) begin
            init_done <= 1'b0;
            started <= 1'b0;
            tx_on <= 1'b0;
            rx_on <= 1'b0;
        end else if (wr_en && i_paddr == `RAFRS_OFF_CTRL) begin
            if (i_pwdata[`RAFRS_CTRL_INIT]) begin
                // init sets the done flag; set wins over a clear in the same write
                init_done <= 1'b1;
                tx_dis_active <= mode[`RAFRS_MODE_TX_DISABLE];
                rx_dis_active <= mode[`RAFRS_MODE_RX_DISABLE];
                tx_on <= started & ~mode[`RAFRS_MODE_TX_DISABLE];
                rx_on <= started & ~mode[`RAFRS_MODE_RX_DISABLE];
            end else if (i_pwdata[`RAFRS_CTRL_INIT_DONE]) begin
                init_done <= 1'b0;
            end
            if (i_pwdata[`RAFRS_CTRL_START] && (init_done || i_pwdata[`RAFRS_CTRL_INIT])) begin
                started <= 1'b1;
                tx_on <= ~(i_pwdata[`RAFRS_CTRL_INIT] ? mode[`RAFRS_MODE_TX_DISABLE]
                           : tx_dis_active);
                rx_on <= ~(i_pwdata[`RAFRS_CTRL_INIT] ? mode[`RAFRS_MODE_RX_DISABLE]
                           : rx_dis_active);
            end
        end
    end

    assign o_tx_ring_enable = tx_on;
    assign o_rx_ring_enable = rx_on;

    assign o_tx_chain_allow = ~loop_on;
    // the lookahead poll only has time when each buffer is exactly 32 bytes
    assign o_rx_chain_allow = ~loop_on | (i_rx_buf_len == `RAFRS_LOOP_CHAIN_BYTES);

    // destination address capture, first received bit lands in addr[0]
    assign last_bit = (bit_cnt == `RAFRS_LAST_BIT);

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            bit_cnt <= 6'h00;
            in_addr <= 1'b0;
            addr <= 48'h000000000000;
            decide <= 1'b0;
        end else begin
            decide <= 1'b0;
            if (i_rx_frame_start) begin
                bit_cnt <= 6'h00;
                in_addr <= 1'b1;
            end else if (in_addr && i_rx_bit_valid) begin
                addr <= {i_rx_bit, addr[47:1]};
                bit_cnt <= bit_cnt + 6'h01;
                if (last_bit) begin
                    in_addr <= 1'b0;
                    decide <= 1'b1;
                end
            end
        end
    end

    rafrs_crc_hash u_hash (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_clear(i_rx_frame_start),
        .i_bit(i_rx_bit),
        .i_bit_valid(in_addr & i_rx_bit_valid),
        .i_last(last_bit),
        .o_index(hash_index)
    );

    assign group_addr = addr[0];
    assign broadcast = &addr;

    always @* begin
        next_accept = 1'b0;
        if (!rx_on) begin
            next_accept = 1'b0;
        end else if (broadcast) begin
            next_accept = 1'b1;
        end else if (group_addr) begin
            // without crc disable the shared crc unit is busy on the tx side
            if (ext_loop && !mode[`RAFRS_MODE_TX_CRC_DISABLE]) begin
                next_accept = 1'b0;
            end else begin
                next_accept = hash_mask[hash_index];
            end
        end else begin
            next_accept = (addr == station);
        end
    end

    always @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rx_accept <= 1'b0;
            o_rx_reject <= 1'b0;
            o_rx_group <= 1'b0;
        end else begin
            o_rx_accept <= decide & next_accept;
            o_rx_reject <= decide & ~next_accept;
            if (decide) begin
                o_rx_group <= group_addr;
            end
        end
    end

    rafrs_ring_decode u_ring (
        .i_ring_ptr(ring_ptr),
        .o_base(o_rx_ring_base),
        .o_entries(o_rx_ring_entries)
    );
endmodule

// File: tb_rx_address_filter_ring_setup.sv
// self-checking bench for the address filter and ring setup block
`timescale 1ns/1ps
`include "rafrs_consts.vh"
module tb_rx_address_filter_ring_setup;
    logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, go = 0, se;
    logic [7:0] paddr = 0;
    logic [31:0] pwd = 0, rd, prdata;
    logic [15:0] blen = 16'h0020;
    logic [47:0] dst = 0;
    logic pready, pslverr, fs, rbit, rval, acc, rej, grp, ten, ren, tch, rch;
    logic [47:0] near_grp;
    logic [23:0] base;
    logic [7:0] ents;
    int n_fail = 0, cmp_count = 0, cyc = 0;
    localparam logic [47:0] STA = 48'h0a1b2c3d4e50, GRP = 48'h123456789ab1;
    localparam logic [47:0] BC = 48'hffffffffffff;
    always #20 clk = ~clk;
    rafrs_top uut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_rx_frame_start(fs), .i_rx_bit(rbit),
        .i_rx_bit_valid(rval), .i_rx_buf_len(blen), .o_rx_accept(acc), .o_rx_reject(rej),
        .o_rx_group(grp), .o_tx_ring_enable(ten), .o_rx_ring_enable(ren),
        .o_tx_chain_allow(tch), .o_rx_chain_allow(rch), .o_rx_ring_base(base),
        .o_rx_ring_entries(ents));
    rafrs_frame_src src (.i_core_clk(clk), .i_go(go), .i_addr(dst), .o_start(fs),
        .o_bit(rbit), .o_valid(rval));
    task stop_test;
        if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    function automatic logic [5:0] hidx(input logic [47:0] a);
        logic [31:0] c = 32'hffffffff;
        for (int i = 0; i < 48; i++) c = (c >> 1) ^ ((c[0] ^ a[i]) ? 32'hedb88320 : 32'h0);
        return c[31:26];
    endfunction
    task set_mask(input logic [63:0] m);
        for (int k = 0; k < 4; k++) begin
            apb(1, 8'h14 + 8'(4 * k), {16'h0, m[16 * k +: 16]});
            apb(0, 8'h14 + 8'(4 * k), 0);
            chk("hash word", {16'h0, m[16 * k +: 16]}, rd);
        end
    endtask
    task frame(input logic [47:0] a, input logic ok);
        int k;
        dst <= a;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        k = 0;
        while (acc !== 1'b1 && rej !== 1'b1 && k < 80) begin
            @(posedge clk);
            k++;
        end
        chk("accept", {31'h0, ok}, {31'h0, acc});
        chk("reject", {31'h0, !ok}, {31'h0, rej});
        chk("group", {31'h0, a[0]}, {31'h0, grp});
        @(posedge clk);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("entries", 1, ents);
        chk("rx ring on", 0, ren);
        apb(0, `RAFRS_OFF_MODE, 0);
        chk("mode", 0, rd);
        apb(1, `RAFRS_OFF_RING, 32'hffffffff);
        apb(0, `RAFRS_OFF_RING, 0);
        chk("ring ptr", 32'he0fffff8, rd);
        chk("ring base", 32'hfffff8, base);
        for (int i = 0; i < 8; i++) begin
            apb(1, `RAFRS_OFF_RING, {i[2:0], 29'h8});
            chk("entries", 1 << i, ents);
        end
        apb(0, 8'h40, 0);
        chk("unmapped err", 1, se);
        frame(BC, 0);
        apb(1, `RAFRS_OFF_STA0, 32'h4e50);
        apb(1, `RAFRS_OFF_STA1, 32'h2c3d);
        apb(1, `RAFRS_OFF_STA2, 32'h0a1b);
        set_mask(0);
        apb(1, `RAFRS_OFF_CTRL, 32'h3);
        apb(0, `RAFRS_OFF_CTRL, 0);
        chk("on flags", 3, rd[5:4]);
        frame(STA, 1);
        frame(STA ^ 48'h2, 0);
        frame(BC, 1);
        frame(GRP, 0);
        set_mask(64'h1 << hidx(GRP));
        frame(GRP, 1);
        // another group address in the same hash bucket: only a possible match
        near_grp = GRP;
        while (near_grp == GRP || hidx(near_grp) != hidx(GRP)) near_grp = near_grp + 48'h2;
        frame(near_grp, 1);
        apb(1, `RAFRS_OFF_MODE, 32'h4);
        chk("tx chain", 0, tch);
        chk("rx chain", 1, rch);
        blen <= 16'h0021;
        @(posedge clk);
        chk("rx chain", 0, rch);
        frame(GRP, 0);
        apb(1, `RAFRS_OFF_MODE, 32'h44);
        frame(GRP, 1);
        apb(1, `RAFRS_OFF_MODE, 32'hc);
        frame(GRP, 1);
        apb(1, `RAFRS_OFF_MODE, 32'h3);
        apb(1, `RAFRS_OFF_CTRL, 32'h1);
        chk("tx ring on", 0, ten);
        chk("rx ring on", 0, ren);
        frame(BC, 0);
        apb(0, `RAFRS_OFF_CTRL, 0);
        chk("ctrl", 32'h102, rd);
        apb(1, `RAFRS_OFF_CTRL, 32'h4);
        apb(0, `RAFRS_OFF_CTRL, 0);
        chk("stopped", 32'h4, rd);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk("entries", 1, ents);
        chk("rx ring on", 0, ren);
        apb(0, `RAFRS_OFF_MODE, 0);
        chk("mode", 0, rd);
        stop_test;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_fail++;
            stop_test;
        end
    end
endmodule
bind rafrs_top rafrs_checker chk_i (.i_core_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .o_prdata, .i_rx_buf_len, .o_rx_accept, .o_rx_reject, .o_rx_group,
    .o_tx_ring_enable, .o_rx_ring_enable, .o_tx_chain_allow, .o_rx_chain_allow,
    .o_rx_ring_base, .o_rx_ring_entries);
